// File: hdl/prsa_regs.svh
// Timing counts and field positions for the pump run sequencer.
// Assumes a 40 MHz core clock; included by the package file and the sequencer.
`ifndef PRSA_REGS_SVH
`define PRSA_REGS_SVH
`define PRSA_CLK_HZ 40000000
`define PRSA_SEC_PERIOD_S 1
`define PRSA_SEC_CYCLES (`PRSA_CLK_HZ * `PRSA_SEC_PERIOD_S)
`define PRSA_POINTS 8
`define PRSA_RATE_W 16
`define PRSA_SUM_W 19
`define PRSA_SEC_W 20
`define PRSA_SECS_PER_HOUR 3600
`define PRSA_SECS_PER_MIN 60
`define PRSA_CNT_W 16
`define PRSA_ADC_W 12
`define PRSA_ALM_IN1 0
`define PRSA_ALM_IN2 1
`define PRSA_ALM_TIMEOUT 2
`define PRSA_ALM_CUTOFF 3
`define PRSA_ALM_HIPRES 4
`define PRSA_ALM_LOPRES 5
`define PRSA_ALM_W 6
`endif

// File: hdl/prsa_pkg.sv
// Types for the pump run sequencer.
// Constants come from prsa_regs.svh.
`include "prsa_regs.svh"
package prsa_pkg;
	typedef enum logic [1:0] {PRSA_TIME, PRSA_CYCLE, PRSA_FIXED_MPI} prsa_mode_t;
	typedef enum logic [2:0] {PRSA_PS_OFF, PRSA_PS_NOTIFY, PRSA_PS_MIN,
		PRSA_PS_NORMAL, PRSA_PS_MAX} prsa_psave_t;
	// Hours, minutes, seconds as entered
	typedef struct packed {
		logic [7:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} prsa_hms_t;
	// One alarm input configuration
	typedef struct packed {
		logic enable;
		logic normally_closed;
	} prsa_in_cfg_t;
endpackage : prsa_pkg

// File: hdl/prsa_sequencer.sv
// Pump run sequencer: time/cycle/fixed multi-point run, priming, alarms.
// Assumes pins are raw asynchronous levels; keys are debounced pulses
// from the panel logic on core_clk. Analog values come from same clock.
`timescale 1ns/100ps
`include "prsa_regs.svh"
module prsa_sequencer #(
	parameter int unsigned SEC_CYCLES = `PRSA_SEC_CYCLES,
	parameter int unsigned POINTS = `PRSA_POINTS
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire prsa_pkg::prsa_mode_t mode,
	input wire logic multi_point_unit,
	input wire logic variable_speed,
	input wire logic [POINTS*`PRSA_RATE_W-1:0] point_rate,
	input wire logic [POINTS-1:0] point_enable,
	input wire prsa_pkg::prsa_hms_t on_time,
	input wire prsa_pkg::prsa_hms_t off_time,
	input wire prsa_pkg::prsa_hms_t on_timeout,
	input wire logic [`PRSA_CNT_W-1:0] on_cycles,
	input wire logic [`PRSA_CNT_W-1:0] point_dwell_secs,
	input wire logic key_left,
	input wire logic key_right,
	input wire logic key_enter,
	input wire logic key_reset,
	input wire logic cycle_switch_pin,
	input wire logic alarm_in1_pin,
	input wire logic alarm_in2_pin,
	input wire logic remote_off_pin,
	input wire prsa_pkg::prsa_in_cfg_t in1_cfg,
	input wire prsa_pkg::prsa_in_cfg_t in2_cfg,
	input wire prsa_pkg::prsa_in_cfg_t remote_cfg,
	input wire logic [`PRSA_ALM_W-1:0] alarm_stop,
	input wire prsa_pkg::prsa_psave_t psave_level,
	input wire logic [`PRSA_ADC_W-1:0] battery_volts,
	input wire logic [`PRSA_ADC_W-1:0] power_save_threshold,
	input wire logic [`PRSA_ADC_W-1:0] battery_cutoff_threshold,
	input wire logic [`PRSA_ADC_W-1:0] pressure,
	input wire logic [`PRSA_ADC_W-1:0] pressure_high_limit,
	input wire logic [`PRSA_ADC_W-1:0] pressure_low_limit,
	output logic pump_on,
	output logic [POINTS-1:0] solenoid,
	output logic [`PRSA_SUM_W-1:0] total_rate,
	output logic [`PRSA_ALM_W-1:0] alarm_flags,
	output logic halted,
	output logic standby,
	output logic power_save,
	output logic priming
);
	typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PRIME, ST_HALT} st_t;
	localparam int PW = $clog2(POINTS);

	// HH:MM:SS to seconds
	function automatic logic [`PRSA_SEC_W-1:0] hms_secs(
		input prsa_pkg::prsa_hms_t t);
		hms_secs = `PRSA_SEC_W'(t.hh * `PRSA_SECS_PER_HOUR
			+ t.mm * `PRSA_SECS_PER_MIN + t.ss);
	endfunction : hms_secs

	// Alarm input active level per polarity
	function automatic logic in_active(input prsa_pkg::prsa_in_cfg_t c,
		input logic lvl);
		in_active = c.enable & (c.normally_closed ? ~lvl : lvl);
	endfunction : in_active

	// Two-flop synchronisers on the four pins; settle masks the
	// reset value of the chain so no false edge or alarm follows reset
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [2:0] settle;
	logic cyc_prev;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
			settle <= 3'h0;
			cyc_prev <= 1'b0;
		end
		else
		begin
			pin_meta <= {remote_off_pin, alarm_in2_pin, alarm_in1_pin,
				cycle_switch_pin};
			pin_sync <= pin_meta;
			settle <= {settle[1:0], 1'b1};
			cyc_prev <= pin_sync[0];
		end
	end
	wire cycle_pulse = pin_sync[0] & ~cyc_prev & settle[2];

	// One-second tick; restarted on each phase change so a phase
	// entered between ticks still lasts its full programmed seconds
	st_t state;
	st_t state_q;
	logic [31:0] div_cnt;
	wire phase_edge = (state != state_q);
	wire sec_tick = (div_cnt == SEC_CYCLES - 1) && !phase_edge;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_cnt <= 32'h0;
			state_q <= ST_RUN;
		end
		else
		begin
			div_cnt <= (sec_tick || phase_edge) ? 32'h0 : div_cnt + 32'h1;
			state_q <= state;
		end
	end

	// Total rate of enabled points
	logic [`PRSA_SUM_W-1:0] next_total;
	always_comb
	begin
		next_total = '0;
		for (int i = 0; i < POINTS; i++)
			if (point_enable[i])
				next_total = next_total + `PRSA_SUM_W'(
					point_rate[i*`PRSA_RATE_W +: `PRSA_RATE_W]);
	end
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			total_rate <= '0;
		else
			total_rate <= next_total;
	end

	// Power save decision and on-time scaling
	wire ps_allowed = (psave_level != prsa_pkg::PRSA_PS_OFF);
	wire ps_enter = ps_allowed & (battery_volts < power_save_threshold);
	wire ps_notify_only = (psave_level == prsa_pkg::PRSA_PS_NOTIFY)
		| (multi_point_unit & variable_speed);
	wire [`PRSA_SEC_W-1:0] on_full = hms_secs(on_time);
	wire [`PRSA_SEC_W+1:0] on_x3 = {2'b00, on_full} + {1'b0, on_full, 1'b0};
	logic [`PRSA_SEC_W-1:0] on_scaled;
	always_comb
	begin
		on_scaled = on_full;
		if (ps_enter && !ps_notify_only)
			case (psave_level)
				prsa_pkg::PRSA_PS_MIN: on_scaled = on_x3[`PRSA_SEC_W+1:2];
				prsa_pkg::PRSA_PS_NORMAL: on_scaled = {1'b0, on_full[`PRSA_SEC_W-1:1]};
				prsa_pkg::PRSA_PS_MAX: on_scaled = {2'b00, on_full[`PRSA_SEC_W-1:2]};
				default: on_scaled = on_full;
			endcase
	end

	// Alarm conditions, live
	logic [`PRSA_ALM_W-1:0] alm_cond;
	logic timeout_hit;
	assign alm_cond[`PRSA_ALM_IN1] = settle[1]
		& in_active(in1_cfg, pin_sync[1]);
	assign alm_cond[`PRSA_ALM_IN2] = settle[1]
		& in_active(in2_cfg, pin_sync[2]);
	assign alm_cond[`PRSA_ALM_TIMEOUT] = timeout_hit;
	assign alm_cond[`PRSA_ALM_CUTOFF] =
		battery_volts < battery_cutoff_threshold;
	assign alm_cond[`PRSA_ALM_HIPRES] = pressure > pressure_high_limit;
	assign alm_cond[`PRSA_ALM_LOPRES] = pressure < pressure_low_limit;
	// Enabled remote input holds standby until the pins have settled
	wire remote_now = settle[1] ? in_active(remote_cfg, pin_sync[3])
		: remote_cfg.enable;
	wire stop_hit = |(alm_cond & alarm_stop);
	wire prime_req = key_left & key_right;

	// Sequencer state
	logic [`PRSA_SEC_W-1:0] sec_cnt;
	logic [`PRSA_SEC_W-1:0] tmo_cnt;
	logic tmo_run;
	logic [`PRSA_CNT_W-1:0] cyc_cnt;
	logic [PW-1:0] point;
	wire [`PRSA_SEC_W-1:0] tmo_lim = hms_secs(on_timeout);
	assign timeout_hit = tmo_run && (tmo_cnt >= tmo_lim);

	// Next enabled point after a given one; top bit set when none remains
	function automatic logic [PW:0] next_point(input logic [PW-1:0] cur,
		input logic [POINTS-1:0] en, input logic from_start);
		next_point = {1'b1, {PW{1'b0}}};
		for (int k = POINTS - 1; k >= 0; k--)
			if (en[k] && (from_start || k > int'(cur)))
				next_point = {1'b0, PW'(k)};
	endfunction : next_point
	wire [PW:0] first_pt = next_point('0, point_enable, 1'b1);
	wire [PW:0] step_pt = next_point(point, point_enable, 1'b0);
	wire fixed_mpi = multi_point_unit && (mode == prsa_pkg::PRSA_FIXED_MPI);

	// Run phase end per mode
	logic run_done;
	always_comb
	begin
		case (mode)
			prsa_pkg::PRSA_CYCLE: run_done = (cyc_cnt >= on_cycles);
			prsa_pkg::PRSA_FIXED_MPI: run_done = sec_tick && step_pt[PW]
				&& (sec_cnt + 1'b1 >= `PRSA_SEC_W'(point_dwell_secs));
			default: run_done = sec_tick && (sec_cnt + 1'b1 >= on_scaled);
		endcase
	end

	// Main sequencer; stop alarms preempt every state, priming included
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ST_RUN;
			sec_cnt <= '0;
			cyc_cnt <= '0;
			point <= '0;
		end
		else if (stop_hit && state != ST_HALT)
		begin
			state <= ST_HALT;
			sec_cnt <= '0;
		end
		else
			case (state)
				ST_RUN:
				begin
					if (prime_req)
					begin
						state <= ST_PRIME;
						point <= first_pt[PW-1:0];
					end
					else if (!remote_now)
					begin
						if (cycle_pulse)
							cyc_cnt <= cyc_cnt + 1'b1;
						if (sec_tick)
							sec_cnt <= sec_cnt + 1'b1;
						if (fixed_mpi && sec_tick && !run_done
							&& sec_cnt + 1'b1 >= `PRSA_SEC_W'(point_dwell_secs))
						begin
							point <= step_pt[PW-1:0];
							sec_cnt <= '0;
						end
						if (run_done)
						begin
							state <= ST_IDLE;
							sec_cnt <= '0;
							cyc_cnt <= '0;
						end
					end
				end
				ST_IDLE:
					if (prime_req)
					begin
						state <= ST_PRIME;
						point <= first_pt[PW-1:0];
					end
					else if (sec_tick)
					begin
						sec_cnt <= sec_cnt + 1'b1;
						if (sec_cnt + 1'b1 >= hms_secs(off_time))
						begin
							state <= ST_RUN;
							sec_cnt <= '0;
							point <= first_pt[PW-1:0];
						end
					end
				ST_PRIME:
					if (key_reset)
					begin
						state <= ST_RUN;
						sec_cnt <= '0;
						cyc_cnt <= '0;
						point <= first_pt[PW-1:0];
					end
					else if (key_enter && multi_point_unit && !step_pt[PW])
						point <= step_pt[PW-1:0];
				ST_HALT:
					if (key_reset && !(|(alm_cond & alarm_stop)))
					begin
						state <= ST_RUN;
						sec_cnt <= '0;
						cyc_cnt <= '0;
						point <= first_pt[PW-1:0];
					end
				default: state <= ST_RUN;
			endcase
	end

	// Missing-cycle timer: starts at idle expiry, restarts per cycle
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tmo_run <= 1'b0;
			tmo_cnt <= '0;
		end
		else if (mode != prsa_pkg::PRSA_CYCLE || state != ST_RUN)
		begin
			tmo_run <= (state == ST_IDLE) && (mode == prsa_pkg::PRSA_CYCLE);
			tmo_cnt <= '0;
		end
		else if (cycle_pulse)
			tmo_cnt <= '0;
		else if (sec_tick && !timeout_hit && !remote_now)
			tmo_cnt <= tmo_cnt + 1'b1;
	end

	// Sticky alarm flags; set wins over reset-key clear
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			alarm_flags <= '0;
		else
			alarm_flags <= alm_cond | (key_reset ? '0 : alarm_flags);
	end

	// Registered outputs
	wire run_pump = (state == ST_PRIME)
		|| (state == ST_RUN && !remote_now && !stop_hit);
	wire mpi_out = multi_point_unit && !first_pt[PW]
		&& (fixed_mpi || state == ST_PRIME);
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pump_on <= 1'b0;
			solenoid <= '0;
			halted <= 1'b0;
			standby <= 1'b0;
			power_save <= 1'b0;
			priming <= 1'b0;
		end
		else
		begin
			pump_on <= run_pump;
			solenoid <= (run_pump && mpi_out) ? POINTS'(1) << point : '0;
			halted <= (state == ST_HALT);
			standby <= remote_now;
			power_save <= ps_enter;
			priming <= (state == ST_PRIME);
		end
	end
endmodule : prsa_sequencer

// File: tb/prsa_sequencer_props.sv
// Port checker for the pump run sequencer.
// Assumes it is bound onto prsa_sequencer and sees its ports only.
`timescale 1ns/100ps
module prsa_sequencer_props #(
	parameter int unsigned SEC_CYCLES = 10,
	parameter int unsigned POINTS = 8
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [POINTS*16-1:0] point_rate,
	input wire logic [POINTS-1:0] point_enable,
	input wire logic key_reset,
	input wire prsa_pkg::prsa_psave_t psave_level,
	input wire logic [11:0] battery_volts,
	input wire logic [11:0] power_save_threshold,
	input wire logic [11:0] battery_cutoff_threshold,
	input wire logic [11:0] pressure,
	input wire logic [11:0] pressure_high_limit,
	input wire logic pump_on,
	input wire logic [POINTS-1:0] solenoid,
	input wire logic [18:0] total_rate,
	input wire logic [5:0] alarm_flags,
	input wire logic halted,
	input wire logic standby,
	input wire logic power_save
);
	logic [18:0] rate_sum;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Reference total, one cycle ahead of the registered output
	always_comb
	begin
		rate_sum = 19'h00000;
		for (int i = 0; i < POINTS; i++)
			if (point_enable[i])
				rate_sum += 19'(point_rate[16*i +: 16]);
	end
	a_total_rate_sum: assert property (
		$past(resetn) |-> total_rate == $past(rate_sum)) else $error("bad total");
	a_solenoid_onehot: assert property ($onehot0(solenoid))
		else $error("two solenoids open");
	a_halt_stops_pump: assert property (
		halted && $past(halted) |-> !pump_on) else $error("pump on while halted");
	a_standby_pump_off: assert property (
		standby && $past(standby) |-> !pump_on) else $error("pump on in standby");
	a_high_press_flag: assert property (
		pressure > pressure_high_limit |=> alarm_flags[4]) else $error("no hi flag");
	a_cutoff_flag: assert property (
		battery_volts < battery_cutoff_threshold |=> alarm_flags[3])
		else $error("no cutoff flag");
	a_flags_sticky: assert property (!key_reset |=>
		(alarm_flags & $past(alarm_flags)) == $past(alarm_flags))
		else $error("flag dropped without reset");
	a_psave_entry: assert property (
		(psave_level != prsa_pkg::PRSA_PS_OFF &&
		battery_volts < power_save_threshold) [*3] |-> power_save)
		else $error("power save not entered");
	c_halted: cover property ($rose(halted));
	c_standby: cover property ($rose(standby));
	c_timeout: cover property ($rose(alarm_flags[2]));
endmodule : prsa_sequencer_props
bind prsa_sequencer prsa_sequencer_props #(.SEC_CYCLES(SEC_CYCLES),
	.POINTS(POINTS)) prsa_sequencer_props_inst (.*);

// File: tb/prsa_cam_model.sv
// Pump motor and cam with its cycle switch.
// Assumes pump_on powers the motor; cam_ok low models a seized cam.
`timescale 1ns/100ps
module prsa_cam_model #(
	parameter int unsigned TURN = 8
) (
	input wire logic core_clk,
	input wire logic pump_on,
	input wire logic cam_ok,
	output logic cycle_switch_pin
);
	logic [7:0] pos = 8'h00;
	// Cam only turns while powered, so the switch freezes when off
	always @(posedge core_clk)
		if (pump_on && cam_ok)
			pos <= (pos == 8'(TURN - 1)) ? 8'h00 : pos + 8'h01;
	assign cycle_switch_pin = (pos < 8'(TURN / 2)); // Closed half a turn
endmodule : prsa_cam_model

// File: tb/prsa_sequencer_tb.sv
// Self-checking bench for the pump run sequencer.
// Assumes package, design, cam model and checker compile first.
`timescale 1ns/100ps
module prsa_sequencer_tb;
	localparam int unsigned SEC = 10; // Short second keeps the run brief
	logic core_clk = 1'b0, resetn = 1'b0, cam_ok = 1'b1;
	prsa_pkg::prsa_mode_t mode = prsa_pkg::PRSA_TIME;
	logic multi_point_unit = 1'b0, variable_speed = 1'b0;
	logic [127:0] point_rate = '0;
	logic [7:0] point_enable = 8'h00, solenoid;
	prsa_pkg::prsa_hms_t on_time = 20'h2, off_time = 20'h1, on_timeout = 20'h3;
	logic [15:0] on_cycles = 16'h3, point_dwell_secs = 16'h1;
	logic key_left = 1'b0, key_right = 1'b0, key_enter = 1'b0, key_reset = 1'b0;
	logic alarm_in1_pin = 1'b0, alarm_in2_pin = 1'b1, remote_off_pin = 1'b0;
	prsa_pkg::prsa_in_cfg_t in1_cfg = '0, in2_cfg = '0, remote_cfg = '0;
	logic [5:0] alarm_stop = 6'h00, alarm_flags;
	prsa_pkg::prsa_psave_t psave_level = prsa_pkg::PRSA_PS_OFF;
	logic [11:0] battery_volts = 12'hc00, power_save_threshold = 12'h800;
	logic [11:0] battery_cutoff_threshold = 12'h400, pressure = 12'h800;
	logic [11:0] pressure_high_limit = 12'hc00, pressure_low_limit = 12'h100;
	logic cycle_switch_pin, pump_on, halted, standby, power_save, priming;
	logic [18:0] total_rate;
	int n_fail = 0, compares = 0;
	prsa_sequencer #(.SEC_CYCLES(SEC)) prsa_sequencer_inst (.*);
	prsa_cam_model prsa_cam_model_inst (.core_clk(core_clk), .pump_on(pump_on),
		.cam_ok(cam_ok), .cycle_switch_pin(cycle_switch_pin));
	always #12.5 core_clk = ~core_clk;
	task tally_and_finish;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task chk(input string what, input logic [18:0] exp, input logic [18:0] got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task chk_rng(input string what, input int lo, input int hi, input int got);
		compares++;
		if (got < lo || got > hi)
		begin
			n_fail++;
			$display("MISMATCH %s exp %0d..%0d got %0d", what, lo, hi, got);
		end
	endtask : chk_rng
	task wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask : wait_n
	// Pulse {left, right, enter, reset} for one cycle
	task keys(input logic [3:0] k);
		@(posedge core_clk) {key_left, key_right, key_enter, key_reset} <= k;
		@(posedge core_clk) {key_left, key_right, key_enter, key_reset} <= 4'h0;
	endtask : keys
	// Length of one whole on phase; skips a phase already under way
	task meas(output int n);
		n = 0;
		wait_n(1);
		repeat (400) if (pump_on !== 1'b0) wait_n(1);
		repeat (400) if (pump_on !== 1'b1) wait_n(1);
		while (pump_on === 1'b1 && n < 400)
		begin
			n++;
			wait_n(1);
		end
	endtask : meas
	task t_rate(input logic [15:0] r, input logic [7:0] en, input logic [18:0] e);
		@(posedge core_clk) point_rate <= {8{r}};
		point_enable <= en;
		wait_n(3);
		chk("total_rate", e, total_rate);
	endtask : t_rate
	// Every level at 8 s on time with the battery low
	task t_psave;
		int n, s;
		@(posedge core_clk) on_time <= 20'h8;
		battery_volts <= 12'h600;
		for (int i = 0; i < 5; i++)
		begin
			@(posedge core_clk) psave_level <= prsa_pkg::prsa_psave_t'(i);
			s = (i < 2) ? 8 : 10 - 2 * i;
			meas(n);
			meas(n);
			chk_rng("on_len", (s - 1) * SEC + 1, s * SEC + 2, n);
			chk("power_save", 19'(i != 0), 19'(power_save));
		end
		// Variable-speed multi-point unit keeps the full on time
		@(posedge core_clk) multi_point_unit <= 1'b1;
		variable_speed <= 1'b1;
		meas(n);
		meas(n);
		chk_rng("vs_on_len", 7 * SEC + 1, 8 * SEC + 2, n);
		@(posedge core_clk) on_time <= 20'h2;
		battery_volts <= 12'hc00;
		psave_level <= prsa_pkg::PRSA_PS_OFF;
		multi_point_unit <= 1'b0;
		variable_speed <= 1'b0;
	endtask : t_psave
	task t_prime;
		keys(4'hc);
		wait_n(40); // Longer than a whole on/off period
		chk("prime_pump", 1'b1, pump_on);
		keys(4'h1);
		wait_n(3);
		chk("priming", 1'b0, priming);
		@(posedge core_clk) multi_point_unit <= 1'b1;
		point_enable <= 8'h24;
		keys(4'hc);
		wait_n(4);
		chk("solenoid", 8'h04, solenoid);
		keys(4'h2);
		wait_n(4);
		chk("solenoid", 8'h20, solenoid);
		keys(4'h1);
		wait_n(3);
		chk("priming", 1'b0, priming);
		@(posedge core_clk) multi_point_unit <= 1'b0;
	endtask : t_prime
	task t_alarm;
		@(posedge core_clk) in1_cfg <= 2'b10;
		alarm_stop <= 6'h01;
		alarm_in1_pin <= 1'b1;
		wait_n(6);
		chk("halted", 1'b1, halted);
		@(posedge core_clk) alarm_in1_pin <= 1'b0;
		wait_n(6);
		chk("halt_holds", 1'b1, halted);
		keys(4'h1);
		wait_n(3);
		chk("halted", 1'b0, halted);
		@(posedge core_clk) in2_cfg <= 2'b11;
		alarm_in2_pin <= 1'b0;
		remote_cfg <= 2'b10;
		remote_off_pin <= 1'b1;
		wait_n(6);
		chk("flags", 6'h02, alarm_flags);
		chk("standby", 1'b1, standby);
		@(posedge core_clk) alarm_in2_pin <= 1'b1;
		remote_off_pin <= 1'b0;
		wait_n(4); // Let the pins pass the synchroniser before clearing
		keys(4'h1);
		wait_n(6);
		chk("standby", 1'b0, standby);
		chk("flags_clr", 6'h00, alarm_flags);
	endtask : t_alarm
	// Fixed scheme on points 2 and 5, one second each, then off
	task t_fixed;
		@(posedge core_clk) mode <= prsa_pkg::PRSA_FIXED_MPI;
		multi_point_unit <= 1'b1;
		wait_n(1);
		repeat (400) if (pump_on !== 1'b0) wait_n(1);
		repeat (400) if (pump_on !== 1'b1) wait_n(1);
		chk("solenoid", 8'h04, solenoid);
		wait_n(SEC + 2);
		chk("solenoid", 8'h20, solenoid);
		wait_n(SEC);
		chk("fixed_off", 1'b0, pump_on);
		chk("solenoid", 8'h00, solenoid);
		@(posedge core_clk) mode <= prsa_pkg::PRSA_TIME;
		multi_point_unit <= 1'b0;
	endtask : t_fixed
	task t_analog;
		@(posedge core_clk) pressure <= 12'hc00;
		wait_n(3);
		chk("flags", 6'h00, alarm_flags);
		@(posedge core_clk) pressure <= 12'hc01;
		battery_volts <= 12'h3ff;
		wait_n(3);
		chk("flags", 6'h18, alarm_flags);
		@(posedge core_clk) pressure <= 12'h0ff;
		wait_n(3);
		chk("lo_press", 1'b1, alarm_flags[5]);
		@(posedge core_clk) pressure <= 12'h800;
		battery_volts <= 12'hc00;
		keys(4'h1);
	endtask : t_analog
	task t_cycle;
		int n;
		@(posedge core_clk) mode <= prsa_pkg::PRSA_CYCLE;
		meas(n);
		meas(n);
		chk_rng("cycle_on", 17, 40, n);
		wait_n(SEC / 2);
		chk("idle", 1'b0, pump_on);
		repeat (40) if (pump_on !== 1'b1) wait_n(1);
		@(posedge core_clk) cam_ok <= 1'b0;
		repeat (200) if (alarm_flags[2] !== 1'b1) wait_n(1);
		chk("timeout", 1'b1, alarm_flags[2]);
		chk("notify_run", 1'b1, pump_on);
	endtask : t_cycle
	initial
	begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		t_rate(16'h1234, 8'ha5, 19'h048d0);
		t_rate(16'hffff, 8'hff, 19'h7fff8);
		t_psave();
		t_prime();
		t_alarm();
		t_analog();
		t_fixed();
		t_cycle();
		tally_and_finish();
	end
	// About six times the expected run length
	initial
	begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule : prsa_sequencer_tb
